//--- common/host_access_pkg.sv
// Constants, field layout and reset values shared by the host access block.
package host_access_pkg;

  // ----------------------------------------------------------------
  // Clock and serial bit rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int RATE_9K6_HZ = 9_600;
  localparam int RATE_31K25_HZ = 31_250;
  localparam int RATE_38K4_HZ = 38_400;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_9K6 = DIV_W'(CLK_HZ / RATE_9K6_HZ);
  localparam logic [DIV_W-1:0] DIV_31K25 = DIV_W'(CLK_HZ / RATE_31K25_HZ);
  localparam logic [DIV_W-1:0] DIV_38K4 = DIV_W'(CLK_HZ / RATE_38K4_HZ);

  typedef enum logic [1:0] {
    RATE_9K6 = 2'b00,
    RATE_31K25 = 2'b01,
    RATE_38K4 = 2'b10,
    RATE_HOLD = 2'b11
  } rate_e;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_EVENT_FLAG = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFF_POINTER = 8'h08;
  localparam logic [7:0] OFF_WINDOW = 8'h0C;
  localparam logic [7:0] OFF_SER_CTRL_STAT = 8'h10;
  localparam logic [7:0] OFF_SER_BUFFER = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_RX_BIT = 0;
  localparam int FLAG_TX_BIT = 1;
  localparam int FLAG_LINE_BIT = 2;
  localparam int FLAG_TIMER_BIT = 3;
  localparam int FLAG_SERIAL_BIT = 4;
  localparam int NUM_FLAGS = 4;
  localparam int NUM_IRQ = 5;
  localparam int PTR_AUTOINC_BIT = 7;
  localparam int SER_RIE_BIT = 7;
  localparam int SER_TXC_LSB = 5;
  localparam int ST_RBF_BIT = 0;
  localparam int ST_TBE_BIT = 1;
  localparam int ST_CTS_BIT = 3;
  localparam int ST_FE_BIT = 4;
  localparam int ST_OV_BIT = 5;
  localparam int ST_IRQ_BIT = 7;
  localparam logic [1:0] TXC_IRQ_EN = 2'b01;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] SER_CTRL_RST = 8'h03;
  localparam logic [NUM_IRQ-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : host_access_pkg

//--- common/serial_if.sv
// Control and status carrier between the host access core and the serial port.
interface serial_if;
  logic [1:0] rate;
  logic rie;
  logic [1:0] txc;
  logic wr_tx;
  logic [7:0] wr_data;
  logic rd_rx;
  logic [7:0] status;
  logic [7:0] rx_data;

  modport host (output rate, output rie, output txc, output wr_tx, output wr_data, output rd_rx,
                input status, input rx_data);
  modport port (input rate, input rie, input txc, input wr_tx, input wr_data, input rd_rx,
                output status, output rx_data);
endinterface : serial_if

//--- logic/host_indirect_access_irq.sv
// AXI4-Lite host port with indirect register window and interrupt gathering.
// How it works
// - Window read returns slot selected by pointer.
// - Window write stores into slot selected by pointer.
// - Pointer top bit enables index step per access.
// - Pointer 80h then reads slots zero upward.
// - Five interrupt sources can raise the interrupt.
// - Reading event flags clears all four flags.
// - Serial data read clears receive interrupt.
// - Serial transmit write clears transmit interrupt.
// - Rate field 00/01/10 picks 9.6/31.25/38.4 kHz.
// - Rate 11 after reset holds serial port idle.
// - Serial status bit 7 mirrors serial interrupt.
module host_indirect_access_irq #(
  parameter int AW = 8,
  parameter int DEPTH = 64
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TIMECODE_RX_EVENT,
  input wire logic TIMECODE_TX_EVENT,
  input wire logic LINE_COUNT_EVENT,
  input wire logic INTERVAL_TIMER_EVENT,
  input wire logic SER_CTS_N,
  input wire logic SER_RX_VALID,
  input wire logic [7:0] SER_RX_BYTE,
  input wire logic SER_RX_FRAME_ERR,
  input wire logic SER_TX_TAKEN,
  output logic SER_TX_VALID,
  output logic [7:0] SER_TX_BYTE,
  output logic SER_BAUD_TICK,
  output logic IRQ
);
  localparam int IDX_W = $clog2(DEPTH);

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  serial_if sp ();

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic aw_held_q, w_held_q;
  logic [AW-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] slot_q [DEPTH];
  logic [IDX_W-1:0] idx_q;
  logic autoinc_q;
  logic [host_access_pkg::NUM_FLAGS-1:0] flags_q, flag_set, flag_clr;
  logic [host_access_pkg::NUM_IRQ-1:0] mask_q, pending;
  logic [7:0] ser_ctrl_q;

  logic wr_go, rd_go, wr_en;
  logic wr_ptr, wr_win, wr_flag, wr_mask, wr_sctl, wr_sbuf, wr_known;
  logic rd_win, rd_flag, rd_sbuf;
  logic [31:0] rd_val;
  logic rd_known;
  logic [1:0] step;

  function automatic logic hit(input logic [AW-1:0] addr, input logic [7:0] off);
    return {addr[AW-1:2], 2'b00} == AW'(off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write acts once both are held.
  assign wr_go = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_en = wr_go & w_lane0_q;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (S_AXI_AWVALID && awready_q) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (bvalid_q && S_AXI_BREADY) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (S_AXI_WVALID && wready_q) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      w_data_q <= S_AXI_WDATA[7:0];
      w_lane0_q <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (bvalid_q && S_AXI_BREADY) begin
      wready_q <= 1'b1;
    end
  end

  always_comb begin
    wr_ptr = 1'b0;
    wr_win = 1'b0;
    wr_flag = 1'b0;
    wr_mask = 1'b0;
    wr_sctl = 1'b0;
    wr_sbuf = 1'b0;
    wr_known = 1'b1;
    if (hit(aw_addr_q, host_access_pkg::OFF_POINTER)) begin
      wr_ptr = wr_en;
    end else if (hit(aw_addr_q, host_access_pkg::OFF_WINDOW)) begin
      wr_win = wr_en;
    end else if (hit(aw_addr_q, host_access_pkg::OFF_EVENT_FLAG)) begin
      wr_flag = wr_en;
    end else if (hit(aw_addr_q, host_access_pkg::OFF_IRQ_MASK)) begin
      wr_mask = wr_en;
    end else if (hit(aw_addr_q, host_access_pkg::OFF_SER_CTRL_STAT)) begin
      wr_sctl = wr_en;
    end else if (hit(aw_addr_q, host_access_pkg::OFF_SER_BUFFER)) begin
      wr_sbuf = wr_en;
    end else begin
      wr_known = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      bvalid_q <= 1'b0;
      bresp_q <= host_access_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? host_access_pkg::RESP_OKAY : host_access_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Read side effects act on the address handshake, so the data is fixed then.
  assign rd_go = S_AXI_ARVALID & arready_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_known = 1'b1;
    rd_win = 1'b0;
    rd_flag = 1'b0;
    rd_sbuf = 1'b0;
    if (hit(S_AXI_ARADDR, host_access_pkg::OFF_POINTER)) begin
      rd_val[host_access_pkg::PTR_AUTOINC_BIT] = autoinc_q;
      rd_val[IDX_W-1:0] = idx_q;
    end else if (hit(S_AXI_ARADDR, host_access_pkg::OFF_WINDOW)) begin
      rd_val[7:0] = slot_q[idx_q];
      rd_win = rd_go;
    end else if (hit(S_AXI_ARADDR, host_access_pkg::OFF_EVENT_FLAG)) begin
      rd_val[host_access_pkg::NUM_IRQ-1:0] = pending;
      rd_flag = rd_go;
    end else if (hit(S_AXI_ARADDR, host_access_pkg::OFF_IRQ_MASK)) begin
      rd_val[host_access_pkg::NUM_IRQ-1:0] = mask_q;
    end else if (hit(S_AXI_ARADDR, host_access_pkg::OFF_SER_CTRL_STAT)) begin
      rd_val[7:0] = sp.status;
    end else if (hit(S_AXI_ARADDR, host_access_pkg::OFF_SER_BUFFER)) begin
      rd_val[7:0] = sp.rx_data;
      rd_sbuf = rd_go;
    end else begin
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= host_access_pkg::RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_known ? host_access_pkg::RESP_OKAY : host_access_pkg::RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Indirect pointer and slots
  // ----------------------------------------------------------------
  // A read and a write of the window in one cycle step the index twice.
  assign step = {1'b0, rd_win} + {1'b0, wr_win};

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      idx_q <= '0;
      autoinc_q <= 1'b0;
    end else if (wr_ptr) begin
      idx_q <= w_data_q[IDX_W-1:0];
      autoinc_q <= w_data_q[host_access_pkg::PTR_AUTOINC_BIT];
    end else if (autoinc_q) begin
      idx_q <= idx_q + IDX_W'(step);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_q[i] <= 8'h00;
      end
    end else if (wr_win) begin
      slot_q[idx_q] <= w_data_q;
    end
  end

  // ----------------------------------------------------------------
  // Event flags, mask and interrupt
  // ----------------------------------------------------------------
  // An event in the cycle of the clearing read stays set, so none is lost.
  assign flag_set = {INTERVAL_TIMER_EVENT, LINE_COUNT_EVENT, TIMECODE_TX_EVENT, TIMECODE_RX_EVENT};
  assign flag_clr = {host_access_pkg::NUM_FLAGS{rd_flag}} |
                    ({host_access_pkg::NUM_FLAGS{wr_flag}} & w_data_q[host_access_pkg::NUM_FLAGS-1:0]);

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  assign pending = {sp.status[host_access_pkg::ST_IRQ_BIT], flags_q};

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      mask_q <= host_access_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= w_data_q[host_access_pkg::NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(pending & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Serial port control
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ser_ctrl_q <= host_access_pkg::SER_CTRL_RST;
    end else if (wr_sctl) begin
      ser_ctrl_q <= w_data_q;
    end
  end

  assign sp.rate = ser_ctrl_q[1:0];
  assign sp.rie = ser_ctrl_q[host_access_pkg::SER_RIE_BIT];
  assign sp.txc = ser_ctrl_q[host_access_pkg::SER_TXC_LSB +: 2];
  assign sp.wr_tx = wr_sbuf;
  assign sp.wr_data = w_data_q;
  assign sp.rd_rx = rd_sbuf;

  serial_port_regs u_serial (
    .clk(CORE_CLK),
    .rst(RESET),
    .sp(sp.port),
    .cts_n(SER_CTS_N),
    .rx_valid(SER_RX_VALID),
    .rx_byte(SER_RX_BYTE),
    .rx_frame_err(SER_RX_FRAME_ERR),
    .tx_taken(SER_TX_TAKEN),
    .tx_valid(SER_TX_VALID),
    .tx_byte(SER_TX_BYTE),
    .baud_tick(SER_BAUD_TICK)
  );

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  window_read_data_a: assert property (rd_win |=> S_AXI_RVALID && S_AXI_RDATA[7:0] == $past(slot_q[idx_q]))
    else $error("window read returned wrong slot");
  window_write_store_a: assert property (wr_win |=> slot_q[$past(idx_q)] == $past(w_data_q))
    else $error("window write not stored");
  index_step_a: assert property (autoinc_q && !wr_ptr && (rd_win ^ wr_win) |=> idx_q == $past(idx_q) + 1'b1)
    else $error("index did not step after window access");
  pointer_80_a: assert property (wr_ptr && w_data_q == 8'h80 |=> idx_q == '0 && autoinc_q)
    else $error("pointer 80h did not select slot zero with step");
  event_sets_a: assert property (TIMECODE_RX_EVENT |=> flags_q[0])
    else $error("receiver event lost");
  flag_read_clears_a: assert property (rd_flag && flag_set == '0 |=> flags_q == '0 ##1 1)
    else $error("event flags survived a read");
  flag_read_value_a: assert property (rd_flag |=> S_AXI_RDATA[3:0] == $past(flags_q))
    else $error("event flag read value wrong");
  rate_reset_a: assert property ($fell(RESET) |-> sp.rate == 2'b11)
    else $error("rate field not 11 after reset");
  irq_output_a: assert property (|(pending & mask_q) |=> IRQ)
    else $error("interrupt output missed a pending flag");
  irq_quiet_a: assert property (!(|(pending & mask_q)) |=> !IRQ)
    else $error("interrupt output raised with nothing pending");
endmodule : host_indirect_access_irq

//--- logic/serial_port_regs.sv
// Serial port buffers, status flags, interrupt and bit-rate tick.
module serial_port_regs (
  input wire logic clk,
  input wire logic rst,
  serial_if.port sp,
  input wire logic cts_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_err,
  input wire logic tx_taken,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic baud_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic hold;
  logic rbf_q, ov_q, fe_q, irq_q, tx_valid_q, tick_q;
  logic [7:0] rx_q, tx_q;
  logic [host_access_pkg::DIV_W-1:0] cnt_q;

  function automatic logic [host_access_pkg::DIV_W-1:0] rate_div(input logic [1:0] r);
    if (r == host_access_pkg::RATE_9K6) begin
      return host_access_pkg::DIV_9K6;
    end else if (r == host_access_pkg::RATE_31K25) begin
      return host_access_pkg::DIV_31K25;
    end else begin
      return host_access_pkg::DIV_38K4;
    end
  endfunction : rate_div

  assign hold = (sp.rate == host_access_pkg::RATE_HOLD);

  // ----------------------------------------------------------------
  // Bit-rate divider
  // ----------------------------------------------------------------
  // The tick is truncated to whole clocks, so the 9.6 and 38.4 kHz rates run slightly fast; 31.25 kHz is exact.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (hold) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q <= rate_div(sp.rate) - 1'b1;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Buffers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (hold) begin
      tx_valid_q <= 1'b0;
    end else if (sp.wr_tx) begin
      tx_valid_q <= 1'b1;
      tx_q <= sp.wr_data;
    end else if (tx_taken) begin
      tx_valid_q <= 1'b0;
    end
  end

  // A byte arriving in the cycle of a data read wins over the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rbf_q <= 1'b0;
      ov_q <= 1'b0;
      fe_q <= 1'b0;
      rx_q <= 8'h00;
    end else if (hold) begin
      rbf_q <= 1'b0;
      ov_q <= 1'b0;
      fe_q <= 1'b0;
    end else if (rx_valid) begin
      rbf_q <= 1'b1;
      ov_q <= rbf_q & ~sp.rd_rx;
      fe_q <= rx_frame_err;
      rx_q <= rx_byte;
    end else if (sp.rd_rx) begin
      rbf_q <= 1'b0;
      ov_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (sp.rie & (rbf_q | ov_q)) | ((sp.txc == host_access_pkg::TXC_IRQ_EN) & ~tx_valid_q & ~cts_n);
    end
  end

  always_comb begin
    sp.status = 8'h00;
    sp.status[host_access_pkg::ST_RBF_BIT] = rbf_q;
    sp.status[host_access_pkg::ST_TBE_BIT] = ~tx_valid_q & ~cts_n;
    sp.status[host_access_pkg::ST_CTS_BIT] = cts_n;
    sp.status[host_access_pkg::ST_FE_BIT] = fe_q;
    sp.status[host_access_pkg::ST_OV_BIT] = ov_q;
    sp.status[host_access_pkg::ST_IRQ_BIT] = irq_q;
  end

  assign sp.rx_data = rx_q;
  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_q;
  assign baud_tick = tick_q;

  rx_read_clears_a: assert property (sp.rd_rx && !rx_valid |=> !rbf_q && !ov_q)
    else $error("receive flag survived a data read");
  tx_write_clears_a: assert property (sp.wr_tx && !hold |=> !sp.status[1] ##1 1)
    else $error("transmit empty still set after a write");
  hold_no_tick_a: assert property (hold [*2] |-> !tick_q)
    else $error("bit-rate tick while held in reset");
  rx_irq_raise_a: assert property (sp.rie && rbf_q && !hold |=> irq_q && sp.status[7])
    else $error("receive interrupt not reported");
endmodule : serial_port_regs

//--- testbench/host_model.sv
// Register bus master model standing in for the host processor.
module host_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung = 1'b0;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Released lines show the inverse, so a stale value can never pass.
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    r = 2'b11;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hung = 1'b1;
  endtask : write
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    {d, r} = '1;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hung = 1'b1;
  endtask : read
endmodule : host_model

//--- testbench/testbench.sv
// Self-checking bench for the host access and interrupt block.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {bit wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_s;
  localparam int HZ = 20_000_000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ev = 4'h0;
  logic rxv = 1'b0;
  logic taken = 1'b0;
  logic [7:0] awaddr, araddr, txb;
  logic [31:0] wdata, rdata, got, saved;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic txv, tick, irq;
  int miscompares = 0;
  int n_compared = 0;
  int cnt;
  int divs[3] = '{HZ / 9600, HZ / 31250, HZ / 38400};
  row_s rows[9] = '{'{0, 8'h10, 32'h02, 2'b00}, '{0, 8'h04, 32'h00, 2'b00}, '{1, 8'h08, 32'h83, 2'b00},
    '{1, 8'h0C, 32'h5A, 2'b00}, '{0, 8'h08, 32'h84, 2'b00}, '{1, 8'h08, 32'h03, 2'b00},
    '{0, 8'h0C, 32'h5A, 2'b00}, '{0, 8'h18, 32'h00, 2'b10}, '{1, 8'h18, 32'h77, 2'b10}};
  always #25 clk = ~clk;
  host_model host_model_i (.clk(clk), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  host_indirect_access_irq host_indirect_access_irq_i (.CORE_CLK(clk), .RESET(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TIMECODE_RX_EVENT(ev[0]), .TIMECODE_TX_EVENT(ev[1]),
    .LINE_COUNT_EVENT(ev[2]), .INTERVAL_TIMER_EVENT(ev[3]), .SER_CTS_N(1'b0), .SER_RX_VALID(rxv),
    .SER_RX_BYTE(8'h3C), .SER_RX_FRAME_ERR(1'b0), .SER_TX_TAKEN(taken), .SER_TX_VALID(txv),
    .SER_TX_BYTE(txb), .SER_BAUD_TICK(tick), .IRQ(irq));
  // ------
  // Helpers
  // ------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic guard(input bit bad);
    if (bad) begin
      miscompares++;
      test_done();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.write(a, d, resp);
    guard(host_model_i.hung);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host_model_i.read(a, got, resp);
    guard(host_model_i.hung);
  endtask : rd
  task automatic next_tick();
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (tick !== 1'b1 && cnt < 5000);
    guard(cnt >= 5000);
  endtask : next_tick
  task automatic hold_check();
    cnt = 0;
    repeat (2500) begin
      @(posedge clk);
      if (tick === 1'b1) cnt++;
    end
    chk("held ticks", 32'h0, 32'(cnt));
  endtask : hold_check
  task automatic pulse(input logic [3:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 4'h0;
    repeat (4) @(posedge clk);
  endtask : pulse
  // ------
  // Sequence
  // ------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    hold_check();
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      if (!rows[i].wr) chk("rdata", rows[i].d, got);
      chk("resp", 32'(rows[i].r), 32'(resp));
    end
    $display("table done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, 32'(i));
      next_tick();
      next_tick();
      next_tick();
      chk("tick period", 32'(divs[i]), 32'(cnt));
    end
    $display("rates done");
    wr(8'h04, 32'h10);
    wr(8'h10, 32'h80);
    @(posedge clk);
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq", 32'h1, 32'(irq));
    rd(8'h10);
    chk("status", 32'h83, got);
    rd(8'h00);
    chk("flags", 32'h10, got);
    rd(8'h14);
    chk("rx byte", 32'h3C, got);
    rd(8'h10);
    chk("status", 32'h02, got);
    chk("irq", 32'h0, 32'(irq));
    wr(8'h10, 32'h20);
    rd(8'h10);
    chk("status", 32'h82, got);
    wr(8'h14, 32'h55);
    rd(8'h10);
    chk("status", 32'h00, got);
    chk("tx", 32'h155, {23'h0, txv, txb});
    @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h10);
    chk("status", 32'h82, got);
    $display("serial done");
    wr(8'h10, 32'h00);
    wr(8'h04, 32'h0F);
    for (int i = 0; i < 4; i++) begin
      pulse(4'(1 << i));
      chk("irq", 32'h1, 32'(irq));
      rd(8'h00);
      chk("flags", 32'(1 << i), got);
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
    end
    pulse(4'hF);
    rd(8'h00);
    saved = got;
    rd(8'h00);
    chk("saved flags", 32'h0F, saved);
    chk("flags", 32'h00, got);
    wr(8'h04, 32'h00);
    pulse(4'h1);
    chk("irq", 32'h0, 32'(irq));
    pulse(4'h2);
    wr(8'h00, 32'h01);
    rd(8'h00);
    chk("flags", 32'h02, got);
    $display("events done");
    wr(8'h08, 32'h80);
    for (int i = 0; i < 8; i++) wr(8'h0C, 32'h30 + 32'(i));
    wr(8'h08, 32'h80);
    for (int i = 0; i < 8; i++) begin
      rd(8'h0C);
      chk("slot", 32'h30 + 32'(i), got);
    end
    $display("autoinc done");
    wr(8'h10, 32'h03);
    hold_check();
    $display("rate hold done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    hold_check();
    rd(8'h08);
    chk("pointer", 32'h00, got);
    $display("reset done");
    test_done();
  end
endmodule : testbench
